// ==== include/rtu_pkg.sv ====
package rtu_pkg;

  // ----------------------------------------------------------------------
  // Query field values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  ADDR_BCAST    = 8'h00;
  localparam logic [7:0]  FN_READ_AIN   = 8'h04;
  localparam logic [7:0]  FN_FORCE      = 8'h05;
  localparam logic [7:0]  FN_PRESET     = 8'h06;
  localparam logic [7:0]  FN_EXC_STATUS = 8'h07;
  localparam logic [7:0]  FN_DIAG       = 8'h08;
  localparam logic [15:0] DIAG_ECHO     = 16'h0000;
  localparam logic [15:0] DIAG_RESTART  = 16'h0001;
  localparam logic [15:0] DIAG_LISTEN   = 16'h0004;
  localparam logic [15:0] AIN_CNT_MIN   = 16'h0001;
  localparam logic [15:0] AIN_CNT_MAX   = 16'h007D;
  localparam logic [7:0]  BYTE_OFF      = 8'h00;
  localparam logic [7:0]  BYTE_ON       = 8'hFF;
  localparam logic [15:0] SINGLE_COUNT  = 16'h0001;

  // ----------------------------------------------------------------------
  // Error reply encoding
  // ----------------------------------------------------------------------
  localparam logic [7:0] ERR_FLAG      = 8'h80;
  localparam logic [7:0] EXC_ILL_FUNC  = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR  = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE = 8'h03;

  // ----------------------------------------------------------------------
  // Table sizes and reply lengths
  // ----------------------------------------------------------------------
  localparam logic [16:0] NUM_OUT_POINTS = 17'h00400;
  localparam logic [16:0] NUM_REGS       = 17'h00400;
  localparam logic [16:0] NUM_AIN        = 17'h00100;
  localparam logic [2:0]  ECHO_LEN       = 3'h6;
  localparam logic [2:0]  SHORT_LEN      = 3'h3;
  localparam logic [2:0]  IDX_THIRD      = 3'h2;
  localparam logic [6:0]  ONE_WORD       = 7'h01;

  // ----------------------------------------------------------------------
  // Carriers and enumerations
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  func;
    logic [15:0] field_a;
    logic [15:0] field_b;
  } rtu_query_t;

  typedef struct packed {
    logic        we;
    logic [15:0] idx;
    logic        on;
  } rtu_force_t;

  typedef struct packed {
    logic        we;
    logic [15:0] idx;
    logic [15:0] data;
  } rtu_preset_t;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'b00000001,
    ST_EVAL   = 8'b00000010,
    ST_FWAIT  = 8'b00000100,
    ST_HDR    = 8'b00001000,
    ST_RDREQ  = 8'b00010000,
    ST_RDWAIT = 8'b00100000,
    ST_DHI    = 8'b01000000,
    ST_DLO    = 8'b10000000
  } rtu_state_t;

  typedef enum logic [4:0] {
    K_NONE = 5'b00001,
    K_ECHO = 5'b00010,
    K_AIN  = 5'b00100,
    K_EXC  = 5'b01000,
    K_ERR  = 5'b10000
  } rtu_kind_t;

endpackage

// ==== rtl/rtu_range_chk.sv ====
`timescale 1ns/1ps
module rtu_range_chk #(
  parameter int unsigned W = 16
) (
  // Request span
  input  wire logic [W-1:0] start_i,
  input  wire logic [W-1:0] count_i,
  // Table size
  input  wire logic [W:0]   limit_i,
  // Result
  output logic              ok_o
);

  logic [W:0] span_end;

  // The span is checked one bit wider so a wrap cannot look legal.
  assign span_end = {1'b0, start_i} + {1'b0, count_i};
  assign ok_o     = (span_end <= limit_i);

endmodule

// ==== rtl/rtu_query_handler.sv ====
`timescale 1ns/1ps
module rtu_query_handler (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Station identity
  input  wire logic [7:0]           station_addr_i,
  // Checked query from the framer
  input  wire rtu_pkg::rtu_query_t  query_i,
  input  wire logic                 query_valid_i,
  output logic                      query_ready_o,
  // Controller tables
  input  wire logic                 sweep_start_i,
  output rtu_pkg::rtu_force_t       force_o,
  output rtu_pkg::rtu_preset_t      preset_o,
  output logic                      ain_rd_req_o,
  output logic [15:0]               ain_rd_idx_o,
  input  wire logic [15:0]          ain_rd_data_i,
  input  wire logic [7:0]           exc_status_i,
  // Reply byte stream to the framer
  output logic                      tx_valid_o,
  output logic [7:0]                tx_data_o,
  output logic                      tx_last_o,
  input  wire logic                 tx_ready_i,
  // Mode
  output logic                      listen_only_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  rtu_pkg::rtu_state_t st_ff;
  rtu_pkg::rtu_state_t nxt_st;
  rtu_pkg::rtu_kind_t  kind_ff;
  rtu_pkg::rtu_kind_t  dec_kind;
  rtu_pkg::rtu_query_t q_ff;
  logic [7:0]          code_ff;
  logic [7:0]          dec_code;
  logic [7:0]          stat_ff;
  logic [7:0]          byte_cnt_ff;
  logic [6:0]          words_ff;
  logic [15:0]         ain_idx_ff;
  logic [15:0]         word_ff;
  logic [2:0]          idx_ff;
  logic                listen_ff;
  logic                force_we_ff;
  logic [15:0]         force_idx_ff;
  logic                force_on_ff;
  logic                preset_we_ff;
  logic [15:0]         preset_idx_ff;
  logic [15:0]         preset_data_ff;
  logic                tx_valid_ff;
  logic [7:0]          tx_data_ff;
  logic                tx_last_ff;
  logic                dec_force;
  logic                dec_preset;
  logic                dec_set_listen;
  logic                dec_clr_listen;

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  wire        in_eval      = (st_ff == rtu_pkg::ST_EVAL);
  wire        is_bcast     = (q_ff.addr == rtu_pkg::ADDR_BCAST);
  wire [7:0]  first_data_byte  = q_ff.field_b[15:8];
  wire [7:0]  second_data_byte = q_ff.field_b[7:0];
  wire        d1_on_off    = (first_data_byte == rtu_pkg::BYTE_OFF) ||
                             (first_data_byte == rtu_pkg::BYTE_ON);
  wire        d2_zero      = (second_data_byte == rtu_pkg::BYTE_OFF);
  wire        is_diag      = (q_ff.func == rtu_pkg::FN_DIAG);
  wire        is_restart   = is_diag &&
                             (q_ff.field_a == rtu_pkg::DIAG_RESTART);
  wire        restart_ok   = is_restart && d1_on_off && d2_zero;
  wire        listen_ok    = is_diag &&
                             (q_ff.field_a == rtu_pkg::DIAG_LISTEN) &&
                             (first_data_byte == rtu_pkg::BYTE_OFF) &&
                             d2_zero;
  wire        quiet        = listen_ff && !restart_ok;
  wire        ain_cnt_ok   = (q_ff.field_b >= rtu_pkg::AIN_CNT_MIN) &&
                             (q_ff.field_b <= rtu_pkg::AIN_CNT_MAX);
  wire        ain_rng_ok;
  wire        pt_rng_ok;
  wire        reg_rng_ok;

  rtu_range_chk #(.W(16)) u_ain_rng (
    .start_i (q_ff.field_a),
    .count_i (q_ff.field_b),
    .limit_i (rtu_pkg::NUM_AIN),
    .ok_o    (ain_rng_ok)
  );

  rtu_range_chk #(.W(16)) u_pt_rng (
    .start_i (q_ff.field_a),
    .count_i (rtu_pkg::SINGLE_COUNT),
    .limit_i (rtu_pkg::NUM_OUT_POINTS),
    .ok_o    (pt_rng_ok)
  );

  rtu_range_chk #(.W(16)) u_reg_rng (
    .start_i (q_ff.field_a),
    .count_i (rtu_pkg::SINGLE_COUNT),
    .limit_i (rtu_pkg::NUM_REGS),
    .ok_o    (reg_rng_ok)
  );

  // ----------------------------------------------------------------------
  // Query decision
  // ----------------------------------------------------------------------
  // Errors are decided before the broadcast and listen-only masks, so a
  // silent query never reaches the reply path; a broadcast force or preset still writes the tables unless listen-only mode is set.
  always_comb begin
    dec_kind       = rtu_pkg::K_NONE;
    dec_code       = rtu_pkg::EXC_ILL_FUNC;
    dec_force      = 1'b0;
    dec_preset     = 1'b0;
    dec_set_listen = 1'b0;
    dec_clr_listen = 1'b0;
    case (q_ff.func)
      rtu_pkg::FN_READ_AIN: begin
        if (!ain_cnt_ok) begin
          dec_kind = rtu_pkg::K_ERR;
          dec_code = rtu_pkg::EXC_ILL_VALUE;
        end else if (!ain_rng_ok) begin
          dec_kind = rtu_pkg::K_ERR;
          dec_code = rtu_pkg::EXC_ILL_ADDR;
        end else begin
          dec_kind = rtu_pkg::K_AIN;
        end
      end
      rtu_pkg::FN_FORCE: begin
        if (!(d1_on_off && d2_zero)) begin
          dec_kind = rtu_pkg::K_ERR;
          dec_code = rtu_pkg::EXC_ILL_VALUE;
        end else if (!pt_rng_ok) begin
          dec_kind = rtu_pkg::K_ERR;
          dec_code = rtu_pkg::EXC_ILL_ADDR;
        end else begin
          dec_force = 1'b1;
          dec_kind  = rtu_pkg::K_ECHO;
        end
      end
      rtu_pkg::FN_PRESET: begin
        if (!reg_rng_ok) begin
          dec_kind = rtu_pkg::K_ERR;
          dec_code = rtu_pkg::EXC_ILL_ADDR;
        end else begin
          dec_preset = 1'b1;
          dec_kind   = rtu_pkg::K_ECHO;
        end
      end
      rtu_pkg::FN_EXC_STATUS: begin
        dec_kind = rtu_pkg::K_EXC;
      end
      rtu_pkg::FN_DIAG: begin
        case (q_ff.field_a)
          rtu_pkg::DIAG_ECHO: begin
            dec_kind = rtu_pkg::K_ECHO;
          end
          rtu_pkg::DIAG_RESTART: begin
            if (restart_ok) begin
              dec_clr_listen = 1'b1;
              dec_kind       = rtu_pkg::K_ECHO;
            end else begin
              dec_kind = rtu_pkg::K_ERR;
              dec_code = rtu_pkg::EXC_ILL_VALUE;
            end
          end
          rtu_pkg::DIAG_LISTEN: begin
            dec_set_listen = listen_ok;
          end
          default: begin
            dec_kind = rtu_pkg::K_ERR;
            dec_code = rtu_pkg::EXC_ILL_VALUE;
          end
        endcase
      end
      default: begin
        dec_kind = rtu_pkg::K_ERR;
      end
    endcase
    if (is_bcast) begin
      dec_kind = rtu_pkg::K_NONE;
    end
    if (is_bcast && !(dec_force || dec_preset || is_diag)) begin
      dec_force  = 1'b0;
      dec_preset = 1'b0;
    end
    if (quiet) begin
      dec_kind       = rtu_pkg::K_NONE;
      dec_force      = 1'b0;
      dec_preset     = 1'b0;
      dec_set_listen = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Reply byte selection
  // ----------------------------------------------------------------------
  wire       tx_free   = !tx_valid_ff || tx_ready_i;
  wire       in_hdr    = (st_ff == rtu_pkg::ST_HDR);
  wire       in_dhi    = (st_ff == rtu_pkg::ST_DHI);
  wire       in_dlo    = (st_ff == rtu_pkg::ST_DLO);
  wire       push      = tx_free && (in_hdr || in_dhi || in_dlo);
  wire [2:0] hdr_len   = (kind_ff == rtu_pkg::K_ECHO) ?
                         rtu_pkg::ECHO_LEN : rtu_pkg::SHORT_LEN;
  wire       hdr_end   = (idx_ff == hdr_len - 3'h1);
  wire       last_word = (words_ff == rtu_pkg::ONE_WORD);
  wire [7:0] func_byte = (kind_ff == rtu_pkg::K_ERR) ?
                         (q_ff.func | rtu_pkg::ERR_FLAG) : q_ff.func;
  wire [7:0] third_byte =
    (kind_ff == rtu_pkg::K_ECHO) ? q_ff.field_a[15:8] :
    (kind_ff == rtu_pkg::K_AIN)  ? byte_cnt_ff :
    (kind_ff == rtu_pkg::K_EXC)  ? stat_ff : code_ff;
  wire [7:0] hdr_byte =
    (idx_ff == 3'h0) ? q_ff.addr :
    (idx_ff == 3'h1) ? func_byte :
    (idx_ff == 3'h2) ? third_byte :
    (idx_ff == 3'h3) ? q_ff.field_a[7:0] :
    (idx_ff == 3'h4) ? first_data_byte : second_data_byte;
  wire [7:0] push_byte = in_hdr ? hdr_byte :
                         in_dhi ? word_ff[15:8] : word_ff[7:0];
  wire       push_last = (in_hdr && hdr_end &&
                          (kind_ff != rtu_pkg::K_AIN)) ||
                         (in_dlo && last_word);

  assign query_ready_o = (st_ff == rtu_pkg::ST_IDLE);
  assign ain_rd_req_o  = (st_ff == rtu_pkg::ST_RDREQ);
  assign ain_rd_idx_o  = ain_idx_ff;
  assign tx_valid_o    = tx_valid_ff;
  assign tx_data_o     = tx_data_ff;
  assign tx_last_o     = tx_last_ff;
  assign listen_only_o = listen_ff;
  assign force_o       = '{we: force_we_ff, idx: force_idx_ff,
                           on: force_on_ff};
  assign preset_o      = '{we: preset_we_ff, idx: preset_idx_ff,
                           data: preset_data_ff};

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      rtu_pkg::ST_IDLE:   if (query_valid_i) nxt_st = rtu_pkg::ST_EVAL;
      rtu_pkg::ST_EVAL: begin
        if (dec_force) begin
          nxt_st = rtu_pkg::ST_FWAIT;
        end else if (dec_kind != rtu_pkg::K_NONE) begin
          nxt_st = rtu_pkg::ST_HDR;
        end else begin
          nxt_st = rtu_pkg::ST_IDLE;
        end
      end
      rtu_pkg::ST_FWAIT: begin
        if (sweep_start_i) begin
          nxt_st = (kind_ff == rtu_pkg::K_NONE) ?
                   rtu_pkg::ST_IDLE : rtu_pkg::ST_HDR;
        end
      end
      rtu_pkg::ST_HDR: begin
        if (tx_free && hdr_end) begin
          nxt_st = (kind_ff == rtu_pkg::K_AIN) ?
                   rtu_pkg::ST_RDREQ : rtu_pkg::ST_IDLE;
        end
      end
      rtu_pkg::ST_RDREQ:  nxt_st = rtu_pkg::ST_RDWAIT;
      rtu_pkg::ST_RDWAIT: nxt_st = rtu_pkg::ST_DHI;
      rtu_pkg::ST_DHI:    if (tx_free) nxt_st = rtu_pkg::ST_DLO;
      rtu_pkg::ST_DLO: begin
        if (tx_free) begin
          nxt_st = last_word ? rtu_pkg::ST_IDLE : rtu_pkg::ST_RDREQ;
        end
      end
      default:            nxt_st = rtu_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff     <= rtu_pkg::ST_IDLE;
      kind_ff   <= rtu_pkg::K_NONE;
      listen_ff <= 1'b0;
      idx_ff    <= 3'h0;
    end else begin
      st_ff <= nxt_st;
      if (in_eval) begin
        kind_ff <= dec_kind;
        idx_ff  <= 3'h0;
        if (dec_set_listen) begin
          listen_ff <= 1'b1;
        end else if (dec_clr_listen) begin
          listen_ff <= 1'b0;
        end
      end else if (in_hdr && tx_free) begin
        idx_ff <= idx_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff        <= '0;
      code_ff     <= 8'h00;
      stat_ff     <= 8'h00;
      byte_cnt_ff <= 8'h00;
      words_ff    <= 7'h00;
      ain_idx_ff  <= 16'h0000;
      word_ff     <= 16'h0000;
    end else begin
      if (query_ready_o && query_valid_i) q_ff <= query_i;
      if (in_eval) begin
        code_ff     <= dec_code;
        stat_ff     <= exc_status_i;
        byte_cnt_ff <= {q_ff.field_b[6:0], 1'b0};
        words_ff    <= q_ff.field_b[6:0];
        ain_idx_ff  <= q_ff.field_a;
      end
      if (st_ff == rtu_pkg::ST_RDWAIT) word_ff <= ain_rd_data_i;
      if (in_dlo && tx_free) begin
        ain_idx_ff <= ain_idx_ff + 16'h0001;
        words_ff   <= words_ff - 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Table writes and reply register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      force_we_ff    <= 1'b0;
      force_idx_ff   <= 16'h0000;
      force_on_ff    <= 1'b0;
      preset_we_ff   <= 1'b0;
      preset_idx_ff  <= 16'h0000;
      preset_data_ff <= 16'h0000;
    end else begin
      force_we_ff  <= (st_ff == rtu_pkg::ST_FWAIT) &&
                      sweep_start_i;
      preset_we_ff <= in_eval && dec_preset;
      if (in_eval) begin
        force_idx_ff   <= q_ff.field_a;
        force_on_ff    <= (first_data_byte == rtu_pkg::BYTE_ON);
        preset_idx_ff  <= q_ff.field_a;
        preset_data_ff <= q_ff.field_b;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_valid_ff <= 1'b0;
      tx_data_ff  <= 8'h00;
      tx_last_ff  <= 1'b0;
    end else if (push) begin
      tx_valid_ff <= 1'b1;
      tx_data_ff  <= push_byte;
      tx_last_ff  <= push_last;
    end else if (tx_ready_i) begin
      tx_valid_ff <= 1'b0;
      tx_last_ff  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ain_count_bad: assert property (
    in_eval && !quiet && !is_bcast && q_ff.func == rtu_pkg::FN_READ_AIN &&
    !ain_cnt_ok |=> kind_ff == rtu_pkg::K_ERR &&
    code_ff == rtu_pkg::EXC_ILL_VALUE)
    else $error("bad analog count not refused");
  chk_ain_first_idx: assert property (
    ain_rd_req_o && $past(in_hdr) |-> ain_rd_idx_o == q_ff.field_a)
    else $error("first analog index wrong");
  chk_ain_byte_cnt: assert property (
    in_hdr && push && idx_ff == rtu_pkg::IDX_THIRD &&
    kind_ff == rtu_pkg::K_AIN |=> tx_data_o == {words_ff[6:0], 1'b0})
    else $error("analog byte count wrong");
  chk_ain_hi_first: assert property (
    in_dhi && push |=> tx_data_o == $past(word_ff[15:8]) &&
    in_dlo)
    else $error("analog high byte not first");
  chk_bcast_silent: assert property (
    in_eval && is_bcast |=> kind_ff == rtu_pkg::K_NONE)
    else $error("broadcast query answered");
  chk_force_sweep: assert property (
    force_o.we |-> $past(sweep_start_i) && !$past(force_o.we))
    else $error("force applied outside sweep start");
  chk_echo_copy: assert property (
    in_hdr && push && kind_ff == rtu_pkg::K_ECHO && idx_ff == 3'h5
    |=> tx_data_o == q_ff.field_b[7:0] && tx_last_o)
    else $error("echo reply differs from query");
  chk_exc_status: assert property (
    in_eval && dec_kind == rtu_pkg::K_EXC |=> stat_ff == $past(exc_status_i))
    else $error("exception status not captured");
  chk_listen_enter: assert property (
    in_eval && dec_set_listen |=> listen_only_o && kind_ff == rtu_pkg::K_NONE)
    else $error("listen-only mode not entered");
  chk_listen_quiet: assert property (
    in_eval && listen_ff && !restart_ok |=> kind_ff == rtu_pkg::K_NONE &&
    !preset_o.we)
    else $error("listen-only mode replied or acted");
  chk_restart_clear: assert property (
    in_eval && restart_ok |=> !listen_only_o)
    else $error("restart did not clear listen-only");
  chk_reset_resp: assert property (
    $past(rst_i) |-> !listen_only_o && query_ready_o)
    else $error("reset did not enable replies");

  cov_ain_read:  cover property (in_dlo && push && last_word);
  cov_force_ack: cover property (force_o.we ##[1:20] tx_last_o);
  cov_listen:    cover property (listen_ff ##[1:50] !listen_ff);
  cov_error:     cover property (in_eval && dec_kind == rtu_pkg::K_ERR);

endmodule

// ==== tb/rtu_tbl_model.sv ====
`timescale 1ns/1ps
module rtu_tbl_model (
  // Clock
  input  wire logic        clk_i,
  // Analog table read
  input  wire logic [15:0] idx_i,
  output logic      [15:0] data_o,
  // Sweep marker
  output logic             sweep_o
);
  logic [3:0] cnt_ff;
  initial begin
    cnt_ff  = 4'h0;
    data_o  = 16'h0000;
    sweep_o = 1'b0;
  end
  // The word appears one cycle after the index and a sweep starts
  // every sixteen cycles.
  always @(posedge clk_i) begin
    data_o  <= {idx_i[7:0], 8'h5A};
    cnt_ff  <= cnt_ff + 4'h1;
    sweep_o <= (cnt_ff == 4'hF);
  end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                 clk_i         = 1'b0;
  logic                 rst_i         = 1'b1;
  logic                 query_valid_i = 1'b0;
  logic [7:0]           exc_status_i  = 8'h96;
  rtu_pkg::rtu_query_t  query_i       = '0;
  logic                 query_ready_o, sweep_start_i, ain_rd_req_o;
  logic                 tx_valid_o, tx_last_o, listen_only_o;
  logic [15:0]          ain_rd_idx_o, ain_rd_data_i;
  logic [7:0]           tx_data_o;
  rtu_pkg::rtu_force_t  force_o, fseen;
  rtu_pkg::rtu_preset_t preset_o, pseen;
  logic [7:0]           rx[$];
  int                   mismatches = 0;
  int                   checked    = 0;
  int                   cycles     = 0;
  int                   last_at    = 0;
  int                   n_last     = 0;
  logic                 stall      = 1'b0;
  logic                 tx_ready_i = 1'b1;

  always #5 clk_i = ~clk_i;

  // Back-pressure: with stall set the sink refuses every other cycle.
  always @(posedge clk_i) tx_ready_i <= !(stall && cycles[0]);

  rtu_query_handler DUT (
    .clk_i(clk_i), .rst_i(rst_i), .station_addr_i(8'h11),
    .query_i(query_i), .query_valid_i(query_valid_i),
    .query_ready_o(query_ready_o), .sweep_start_i(sweep_start_i),
    .force_o(force_o), .preset_o(preset_o), .ain_rd_req_o(ain_rd_req_o),
    .ain_rd_idx_o(ain_rd_idx_o), .ain_rd_data_i(ain_rd_data_i),
    .exc_status_i(exc_status_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i),
    .listen_only_o(listen_only_o)
  );

  rtu_tbl_model table_model (
    .clk_i(clk_i), .idx_i(ain_rd_idx_o), .data_o(ain_rd_data_i),
    .sweep_o(sweep_start_i)
  );

  // A byte moves at the next rising edge when valid and ready both stand.
  always @(negedge clk_i) begin
    cycles++;
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
      rx.push_back(tx_data_o);
      if (tx_last_o === 1'b1) begin
        last_at = rx.size();
        n_last++;
      end
    end
    if (force_o.we === 1'b1) fseen = force_o;
    if (preset_o.we === 1'b1) pseen = preset_o;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic run(rtu_pkg::rtu_query_t q, int n, logic [63:0] e);
    rx.delete();
    last_at = 0;
    n_last  = 0;
    fseen = '0;
    pseen = '0;
    query_i <= q;
    query_valid_i <= 1'b1;
    @(negedge clk_i);
    while (query_ready_o !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    query_valid_i <= 1'b0;
    repeat (60) @(posedge clk_i);
    chk("reply length", 16'(rx.size()), 16'(n));
    chk("last marker", 16'(last_at), 16'(n));
    chk("last count", 16'(n_last), 16'(n > 0));
    for (int i = 0; i < n; i++) begin
      chk("reply byte", {8'h00, rx[i]}, {8'h00, e[8*(n-1-i) +: 8]});
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_preset();
    run({8'h11, 8'h06, 16'h0003, 16'hABCD}, 6, 64'h1106_0003_ABCD);
    chk("preset index", pseen.idx, 16'h0003);
    chk("preset data", pseen.data, 16'hABCD);
    run({8'h11, 8'h06, 16'h0400, 16'h0001}, 3, 64'h118602);
    chk("refused preset", {15'h0, pseen.we}, 16'h0000);
  endtask

  task automatic t_ain();
    stall <= 1'b1;
    run({8'h11, 8'h04, 16'h0004, 16'h0002}, 7,
        64'h1104_04_045A_055A);
    stall <= 1'b0;
    run({8'h11, 8'h04, 16'h0000, 16'h0000}, 3,
        64'h118403);
    run({8'h11, 8'h04, 16'h0000, 16'h007E}, 3, 64'h118403);
    run({8'h11, 8'h04, 16'h00FF, 16'h0002}, 3, 64'h118402);
  endtask

  task automatic t_force();
    run({8'h11, 8'h05, 16'h0007, 16'hFF00}, 6, 64'h1105_0007_FF00);
    chk("force index", fseen.idx, 16'h0007);
    chk("force state", {15'h0, fseen.on}, 16'h0001);
    run({8'h11, 8'h05, 16'h0007, 16'h1200}, 3, 64'h118503);
  endtask

  task automatic t_bcast();
    run({8'h00, 8'h06, 16'h0010, 16'h1234}, 0, 64'h0);
    chk("broadcast preset", pseen.data, 16'h1234);
    run({8'h00, 8'h05, 16'h0002, 16'h0000}, 0, 64'h0);
    chk("broadcast force", {fseen.we, fseen.idx[14:0]}, 16'h8002);
  endtask

  task automatic t_diag();
    run({8'h11, 8'h07, 16'h0000, 16'h0000}, 3,
        64'h110796);
    run({8'h11, 8'h08, 16'h0000, 16'h5A3C}, 6,
        64'h1108_0000_5A3C);
    run({8'h11, 8'h08, 16'h0002, 16'h0000}, 3, 64'h118803);
    run({8'h11, 8'h08, 16'h0001, 16'h1200}, 3, 64'h118803);
  endtask

  task automatic t_listen();
    run({8'h11, 8'h08, 16'h0004, 16'h0000}, 0, 64'h0);
    chk("listen set", {15'h0, listen_only_o}, 16'h0001);
    run({8'h11, 8'h06, 16'h0001, 16'h0001}, 0, 64'h0);
    chk("silent preset", {15'h0, pseen.we}, 16'h0000);
    run({8'h00, 8'h08, 16'h0001, 16'h0000}, 0, 64'h0);
    chk("listen cleared", {15'h0, listen_only_o}, 16'h0000);
    run({8'h11, 8'h08, 16'h0001, 16'hFF00}, 6, 64'h1108_0001_FF00);
  endtask

  task automatic t_reset();
    run({8'h11, 8'h08, 16'h0004, 16'h0000}, 0, 64'h0);
    chk("listen before reset", {15'h0, listen_only_o}, 16'h0001);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("listen after reset", {15'h0, listen_only_o}, 16'h0000);
    run({8'h11, 8'h07, 16'h0000, 16'h0000}, 3, 64'h110796);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("listen at reset", {15'h0, listen_only_o}, 16'h0000);
    t_preset();
    t_ain();
    t_force();
    t_bcast();
    t_diag();
    t_listen();
    t_reset();
    report_and_stop();
  end
endmodule
